/* File: io_cell_pkg.sv */
// Shared constants and carrier types for the I/O cell storage control.
// Assumes a 32-bit classic Wishbone slave and a single 250 MHz clock.
package io_cell_pkg;

    // ==========================================================
    // Geometry
    localparam int NUM_ELEM = 6;
    localparam int ADDR_W   = 8;
    localparam int EL_IN0   = 0;
    localparam int EL_IN1   = 1;
    localparam int EL_OUT0  = 2;
    localparam int EL_OUT1  = 3;
    localparam int EL_TRI0  = 4;
    localparam int EL_TRI1  = 5;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_SRVAL   = 8'h04;
    localparam logic [7:0] ADDR_INITVAL = 8'h08;
    localparam logic [7:0] ADDR_SRMODE  = 8'h0C;
    localparam logic [7:0] ADDR_INVERT  = 8'h10;
    localparam logic [7:0] ADDR_CEUSED  = 8'h14;
    localparam logic [7:0] ADDR_STATUS  = 8'h18;

    // ==========================================================
    // Field positions
    localparam int CTRL_ASYNC_BIT = 0;
    localparam int CTRL_DDR_BIT   = 1;
    localparam int CTRL_INIT_BIT  = 2;
    localparam int MODE_RST_OFS   = 6;
    localparam int STAT_PIN_BIT   = 6;
    localparam int INV_ICE        = 0;
    localparam int INV_OCE        = 1;
    localparam int INV_TCE        = 2;
    localparam int INV_SR         = 3;
    localparam int INV_REV        = 4;

    // ==========================================================
    // Reset values
    localparam logic [5:0] SRVAL_RST   = 6'h00;
    localparam logic [5:0] INITVAL_RST = SRVAL_RST;
    localparam logic [5:0] SETEN_RST   = 6'h00;
    localparam logic [5:0] RSTEN_RST   = 6'h00;
    localparam logic [4:0] INVERT_RST  = 5'h00;
    localparam logic [2:0] CEUSED_RST  = 3'h0;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic input_pair_clk_en;
        logic output_pair_clk_en;
        logic tristate_pair_clk_en;
        logic set_reset_in;
        logic reverse_in;
    } ctrl_in_t;

    typedef struct packed {
        logic out_d0;
        logic out_d1;
        logic tri_d0;
        logic tri_d1;
    } fabric_data_t;

    typedef struct packed {
        logic       async_sel;
        logic       ddr_en;
        logic [5:0] sr_value;
        logic [5:0] init_value;
        logic [5:0] set_en;
        logic [5:0] reset_en;
        logic [4:0] invert;
        logic [2:0] ce_used;
    } cfg_t;

    typedef struct packed {
        cfg_t        cfg;
        logic        init_pend;
        logic [5:0]  elem;
        logic [2:0]  pin_sync;
        logic        pin;
        logic        phase;
        logic        pad;
        logic        pad_oe;
        logic        ack;
        logic [31:0] rdata;
    } state_t;

endpackage

/* File: io_cell_storage_control.sv */
// Storage control of one I/O cell: input, output and 3-state register
// pairs, shared set/reset and reverse, init values, DDR output.
// Assumes fabric controls on clk_i and an asynchronous pad input.
//
// Notes on behaviour
// [RQ1] Each register pair has its own clock enable.
// [RQ2] Enables active high; unused enable counts asserted.
// [RQ3] All elements share set/reset and reverse inputs.
// [RQ4] Set/reset loads each element's own value attribute.
// [RQ5] Reverse input forces the opposite value.
// [RQ6] Init value loads after reset or global init.
// [RQ7] Value and init attributes independent per element.
// [RQ8] Sync/async choice common to whole cell.
// [RQ9] Every control input has its own polarity.
// [RQ10] Seven set/reset options per element.
// [RQ11] Reset beats set when both requested.
// [RQ12] DDR output can forward the clock.
// [RQ13] Two registers, alternate phases, muxed onto pad.
`timescale 1ns/1ps
module io_cell_storage_control (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [io_cell_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // Fabric side
    input  wire io_cell_pkg::ctrl_in_t     ctl_i,
    input  wire io_cell_pkg::fabric_data_t fab_i,
    output logic                           in_q0_o,
    output logic                           in_q1_o,
    // Pad side
    input  wire logic                      pad_i,
    output logic                           pad_o,
    output logic                           pad_oe_o
);
    import io_cell_pkg::*;

    state_t     st_r;
    state_t     st_nxt;
    logic [5:0] force0_v;
    logic [5:0] force1_v;
    logic [5:0] ce_elem_v;
    logic [2:0] ce_pair_v;
    logic       sr_act;
    logic       rev_act;

    // ==========================================================
    // Register read view
    function automatic logic [31:0] reg_view(input state_t s,
                                             input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            ADDR_CTRL: begin
                v[CTRL_ASYNC_BIT] = s.cfg.async_sel;
                v[CTRL_DDR_BIT]   = s.cfg.ddr_en;
            end
            ADDR_SRVAL:   v[5:0] = s.cfg.sr_value;
            ADDR_INITVAL: v[5:0] = s.cfg.init_value;
            ADDR_SRMODE: begin
                v[5:0]                         = s.cfg.set_en;
                v[MODE_RST_OFS +: NUM_ELEM]    = s.cfg.reset_en;
            end
            ADDR_INVERT:  v[4:0] = s.cfg.invert;
            ADDR_CEUSED:  v[2:0] = s.cfg.ce_used;
            ADDR_STATUS: begin
                v[5:0]          = s.elem;
                v[STAT_PIN_BIT] = s.pin;
            end
            default:      v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Byte-lane merge of a write into the current view
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  sel);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return m;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic [31:0] wv;
        logic        req;
        logic        load;
        logic        d;
        wv   = 32'h0000_0000;
        req  = 1'b0;
        load = 1'b0;
        d    = 1'b0;
        st_nxt = st_r;

        // Polarity is folded in here, so no extra gate sits in the path
        ce_pair_v[0] = ~st_r.cfg.ce_used[0]
                     | (ctl_i.input_pair_clk_en ^ st_r.cfg.invert[INV_ICE]); // RQ2 RQ9
        ce_pair_v[1] = ~st_r.cfg.ce_used[1]
                     | (ctl_i.output_pair_clk_en ^ st_r.cfg.invert[INV_OCE]); // RQ2 RQ9
        ce_pair_v[2] = ~st_r.cfg.ce_used[2]
                     | (ctl_i.tristate_pair_clk_en ^ st_r.cfg.invert[INV_TCE]); // RQ2 RQ9
        sr_act  = ctl_i.set_reset_in ^ st_r.cfg.invert[INV_SR]; // RQ9 RQ3
        rev_act = ctl_i.reverse_in ^ st_r.cfg.invert[INV_REV]; // RQ9 RQ3

        for (int i = 0; i < NUM_ELEM; i++) begin
            ce_elem_v[i] = ce_pair_v[i/2]; // RQ1
            // Set/reset gives the attribute, reverse its opposite
            force1_v[i] = st_r.cfg.set_en[i]
                & ((sr_act & st_r.cfg.sr_value[i])
                 | (rev_act & ~st_r.cfg.sr_value[i])); // RQ4 RQ5 RQ10
            force0_v[i] = st_r.cfg.reset_en[i]
                & ((sr_act & ~st_r.cfg.sr_value[i])
                 | (rev_act & st_r.cfg.sr_value[i])); // RQ4 RQ5 RQ10
            // Sync forces wait for the enable; async ones do not
            if (!st_r.cfg.async_sel && !ce_elem_v[i]) begin // RQ8
                force1_v[i] = 1'b0;
                force0_v[i] = 1'b0;
            end
        end

        // Pad input: three stages, a change counts once the last two stages agree
        st_nxt.pin_sync = {st_r.pin_sync[1:0], pad_i};
        if (st_r.pin_sync[1] == st_r.pin_sync[2]) begin
            st_nxt.pin = st_r.pin_sync[2];
        end

        st_nxt.phase = st_r.cfg.ddr_en & ~st_r.phase;

        for (int i = 0; i < NUM_ELEM; i++) begin
            unique case (i)
                EL_IN0: begin
                    d    = st_r.pin;
                    load = ~st_r.cfg.ddr_en | ~st_r.phase;
                end
                EL_IN1: begin
                    // Loads every edge at single rate, like the other pairs
                    d    = st_r.pin;
                    load = ~st_r.cfg.ddr_en | st_r.phase;
                end
                EL_OUT0: begin
                    d    = fab_i.out_d0;
                    load = ~st_r.cfg.ddr_en | st_r.phase;
                end
                EL_OUT1: begin
                    d    = fab_i.out_d1;
                    load = ~st_r.cfg.ddr_en | st_r.phase;
                end
                EL_TRI0: begin
                    d    = fab_i.tri_d0;
                    load = ~st_r.cfg.ddr_en | st_r.phase;
                end
                default: begin
                    d    = fab_i.tri_d1;
                    load = ~st_r.cfg.ddr_en | st_r.phase;
                end
            endcase
            if (st_r.init_pend) begin
                st_nxt.elem[i] = st_r.cfg.init_value[i]; // RQ6 RQ7
            end else if (force0_v[i]) begin
                st_nxt.elem[i] = 1'b0; // RQ11
            end else if (force1_v[i]) begin
                st_nxt.elem[i] = 1'b1;
            end else if (ce_elem_v[i] && load) begin
                st_nxt.elem[i] = d; // RQ1
            end
        end

        // Pair launched together, emitted one per phase
        st_nxt.pad = (st_r.cfg.ddr_en && st_r.phase)
                   ? st_r.elem[EL_OUT1] : st_r.elem[EL_OUT0]; // RQ12 RQ13
        st_nxt.pad_oe = (st_r.cfg.ddr_en && st_r.phase)
                      ? ~st_r.elem[EL_TRI1] : ~st_r.elem[EL_TRI0];

        // Wishbone: one wait state, ack drops the cycle after it rose
        req = wb_cyc_i & wb_stb_i & ~st_r.ack;
        st_nxt.ack       = req;
        st_nxt.rdata     = req ? reg_view(st_r, wb_adr_i)
                               : 32'h0000_0000;
        st_nxt.init_pend = 1'b0;
        if (req && wb_we_i) begin
            wv = lane_merge(reg_view(st_r, wb_adr_i), wb_dat_i, wb_sel_i);
            unique case (wb_adr_i)
                ADDR_CTRL: begin
                    st_nxt.cfg.async_sel = wv[CTRL_ASYNC_BIT]; // RQ8
                    st_nxt.cfg.ddr_en    = wv[CTRL_DDR_BIT];
                    st_nxt.init_pend     = wb_sel_i[0]
                                         & wb_dat_i[CTRL_INIT_BIT]; // RQ6
                end
                ADDR_SRVAL:   st_nxt.cfg.sr_value   = wv[5:0]; // RQ7
                ADDR_INITVAL: st_nxt.cfg.init_value = wv[5:0]; // RQ7
                ADDR_SRMODE: begin
                    st_nxt.cfg.set_en   = wv[5:0]; // RQ10
                    st_nxt.cfg.reset_en = wv[MODE_RST_OFS +: NUM_ELEM];
                end
                ADDR_INVERT:  st_nxt.cfg.invert  = wv[4:0]; // RQ9
                ADDR_CEUSED:  st_nxt.cfg.ce_used = wv[2:0]; // RQ2
                default: begin
                end
            endcase
        end

        if (rst_i) begin
            st_nxt                = '0;
            st_nxt.cfg.sr_value   = SRVAL_RST;
            st_nxt.cfg.init_value = INITVAL_RST;
            st_nxt.cfg.set_en     = SETEN_RST;
            st_nxt.cfg.reset_en   = RSTEN_RST;
            st_nxt.cfg.invert     = INVERT_RST;
            st_nxt.cfg.ce_used    = CEUSED_RST;
            st_nxt.elem           = INITVAL_RST; // RQ6
            st_nxt.pad_oe         = ~INITVAL_RST[EL_TRI0];
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign in_q0_o  = st_r.elem[EL_IN0];
    assign in_q1_o  = st_r.elem[EL_IN1];
    assign pad_o    = st_r.pad;
    assign pad_oe_o = st_r.pad_oe;

    // ==========================================================
    // Checks
    property p_pair_enable_hold;
        @(posedge clk_i) disable iff (rst_i)
        (!ce_pair_v[0] && !st_r.init_pend && !st_r.cfg.async_sel)
        |=> st_r.elem[1:0] == $past(st_r.elem[1:0]);
    endproperty
    a_pair_enable_hold: assert property (p_pair_enable_hold) // RQ1
        else $error("input pair changed with its enable low");

    property p_unused_enable;
        @(posedge clk_i) disable iff (rst_i)
        (!st_r.cfg.ce_used[0] && !st_r.cfg.ddr_en && !st_r.init_pend
         && !force0_v[EL_IN0] && !force1_v[EL_IN0])
        |=> st_r.elem[EL_IN0] == $past(st_r.pin);
    endproperty
    a_unused_enable: assert property (p_unused_enable) // RQ2
        else $error("unused enable did not act as asserted");

    property p_in1_sdr_load;
        @(posedge clk_i) disable iff (rst_i)
        (!st_r.cfg.ddr_en && ce_pair_v[0] && !st_r.init_pend
         && !force0_v[EL_IN1] && !force1_v[EL_IN1])
        |=> st_r.elem[EL_IN1] == $past(st_r.pin);
    endproperty
    a_in1_sdr_load: assert property (p_in1_sdr_load) // RQ1
        else $error("second input element did not load at single rate");

    property p_reset_wins;
        @(posedge clk_i) disable iff (rst_i)
        (!st_r.init_pend && (force0_v != 6'h00))
        |=> (st_r.elem & $past(force0_v)) == 6'h00;
    endproperty
    a_reset_wins: assert property (p_reset_wins) // RQ11
        else $error("reset request did not clear element");

    property p_set_value;
        @(posedge clk_i) disable iff (rst_i)
        (!st_r.init_pend && sr_act && !rev_act)
        |=> ((st_r.elem ^ $past(st_r.cfg.sr_value))
             & $past(force0_v | force1_v)) == 6'h00;
    endproperty
    a_set_value: assert property (p_set_value) // RQ4
        else $error("set/reset did not load attribute value");

    property p_reverse_value;
        @(posedge clk_i) disable iff (rst_i)
        (!st_r.init_pend && !sr_act && rev_act)
        |=> ((st_r.elem ^ ~$past(st_r.cfg.sr_value))
             & $past(force0_v | force1_v)) == 6'h00;
    endproperty
    a_reverse_value: assert property (p_reverse_value) // RQ5
        else $error("reverse did not load opposite value");

    property p_init_load;
        @(posedge clk_i) disable iff (rst_i)
        st_r.init_pend |=> st_r.elem == $past(st_r.cfg.init_value);
    endproperty
    a_init_load: assert property (p_init_load) // RQ6
        else $error("global init did not load init values");

    property p_sync_waits;
        @(posedge clk_i) disable iff (rst_i)
        (!st_r.cfg.async_sel && !ce_pair_v[1] && !st_r.init_pend)
        |=> st_r.elem[3:2] == $past(st_r.elem[3:2]);
    endproperty
    a_sync_waits: assert property (p_sync_waits) // RQ8
        else $error("sync set/reset acted without enable");

    property p_async_no_wait;
        @(posedge clk_i) disable iff (rst_i)
        (st_r.cfg.async_sel && !ce_pair_v[1] && !st_r.init_pend
         && sr_act && st_r.cfg.reset_en[EL_OUT0]
         && !st_r.cfg.sr_value[EL_OUT0])
        |=> !st_r.elem[EL_OUT0];
    endproperty
    a_async_no_wait: assert property (p_async_no_wait) // RQ10
        else $error("async clear waited for enable");

    sequence s_ddr_phases;
        (st_r.cfg.ddr_en && !st_r.phase) ##1 (st_r.cfg.ddr_en && st_r.phase);
    endsequence

    property p_ddr_mux;
        @(posedge clk_i) disable iff (rst_i)
        s_ddr_phases |=> (pad_o == $past(st_r.elem[EL_OUT1]))
                         && ($past(pad_o) == $past(st_r.elem[EL_OUT0], 2));
    endproperty
    a_ddr_mux: assert property (p_ddr_mux) // RQ13
        else $error("ddr output did not alternate registers");

    property p_pin_filter;
        @(posedge clk_i) disable iff (rst_i)
        (st_r.pin_sync[1] != st_r.pin_sync[2]) |=> st_r.pin == $past(st_r.pin);
    endproperty
    a_pin_filter: assert property (p_pin_filter)
        else $error("pad input passed before stages agreed");

    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    property p_wb_ack;
        @(posedge clk_i) disable iff (rst_i)
        s_wb_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack)
        else $error("wishbone ack not a single cycle after request");

endmodule // io_cell_storage_control

/* File: pad_partner.sv */
// Behavioural board-side driver sharing the pad wire with the cell.
// Assumes the cell drives the wire only while pad_oe_i is high.
`timescale 1ns/1ps
module pad_partner (
    // Cell side
    input  wire logic pad_o_i,
    input  wire logic pad_oe_i,
    // Board side
    input  wire logic ext_i,
    output logic      wire_o
);
    // ==========================================================
    // Wire resolution
    // The board drives only while the cell has released the wire
    assign wire_o = pad_oe_i ? pad_o_i : ext_i;
endmodule // pad_partner

/* File: testbench.sv */
// Self-checking bench for the I/O cell storage control.
// Assumes a one-cycle registered ack and a filtered pad input.
`timescale 1ns/1ps
module testbench;
    import io_cell_pkg::*;
    logic         clk_i, rst_i, cyc, stb, we, ext, pad_w;
    logic [7:0]   adr;
    logic [31:0]  wdat, rdat, wb_dat_o;
    logic [3:0]   sel;
    logic         wb_ack_o, in_q0_o, in_q1_o, pad_o, pad_oe_o;
    ctrl_in_t     ctl;
    fabric_data_t fab;
    int           mismatches, n_compared;

    io_cell_storage_control u_io_cell_storage_control (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctl_i(ctl),
        .fab_i(fab), .in_q0_o(in_q0_o), .in_q1_o(in_q1_o),
        .pad_i(pad_w), .pad_o(pad_o), .pad_oe_o(pad_oe_o));
    pad_partner u_pad_partner (.pad_o_i(pad_o), .pad_oe_i(pad_oe_o),
        .ext_i(ext), .wire_o(pad_w));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic cycle; caller enters right after a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) chk("wb_ack_o", 1, 0);
        @(posedge clk_i);
    endtask

    task automatic cfg(input logic [31:0] c, v, i, m, inv, ce);
        wb(1'b1, ADDR_SRVAL, v);
        wb(1'b1, ADDR_INITVAL, i);
        wb(1'b1, ADDR_SRMODE, m);
        wb(1'b1, ADDR_INVERT, inv);
        wb(1'b1, ADDR_CEUSED, ce);
        wb(1'b1, ADDR_CTRL, c);
    endtask

    // Pad sync plus filter needs about five cycles; eight leaves margin
    task automatic rs();
        repeat (8) @(posedge clk_i);
        wb(1'b0, ADDR_STATUS, 0);
    endtask

    // Expected STATUS: forces, enabled loads, then the looped-back pin
    function automatic logic [31:0] exp7(input logic [5:0] v, se, re,
                                         input logic s, r);
        logic [5:0] f1, f0, e;
        logic       pin;
        f1 = se & ((s ? v : 6'h00) | (r ? ~v : 6'h00));
        f0 = re & ((s ? ~v : 6'h00) | (r ? v : 6'h00));
        e = {fab.tri_d1, fab.tri_d0, fab.out_d1, fab.out_d0, 2'h0};
        e = (e & ~f1 & ~f0) | (f1 & ~f0);
        pin = e[4] ? ext : e[2];
        e[1:0] = e[1:0] | ({2{pin}} & ~f1[1:0] & ~f0[1:0]);
        return {25'h0, pin, e};
    endfunction

    task automatic test_done();
        $display("Compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [5:0]  v, w, se, re;
        logic [31:0] wd, e;
        logic [31:0] msk [6];
        logic        p;
        void'($urandom(32'h87D24498));
        msk = '{32'h3, 32'h3F, 32'h3F, 32'hFFF, 32'h1F, 32'h7};
        mismatches = 0;
        n_compared = 0;
        {rst_i, cyc, stb, we, ext, adr, wdat} = '0;
        rst_i = 1'b1;
        sel = 4'hF;
        ctl = '0;
        fab = '0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("pad_oe_o", 1, pad_oe_o);
        // Read-only and unmapped places must ignore writes
        wb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        wb(1'b1, 8'h1C, 32'hFFFFFFFF);
        for (int a = 0; a < 32; a += 4) begin
            wb(1'b0, 8'(a), 0);
            chk("reset value", 0, rdat);
        end
        repeat (3) for (int k = 0; k < 6; k++) begin
            wd = $urandom;
            wb(1'b1, 8'(4 * k), wd);
            wb(1'b0, 8'(4 * k), 0);
            chk("readback", wd & msk[k], rdat);
        end
        // Only the selected byte lane may change
        wb(1'b1, ADDR_SRMODE, 0);
        sel <= 4'h2;
        wb(1'b1, ADDR_SRMODE, 32'hFFFFFFFF);
        sel <= 4'hF;
        wb(1'b0, ADDR_SRMODE, 0);
        chk("lane write", 32'hF00, rdat);
        // All set/reset options, both modes, all control pairs
        for (int i = 0; i < 24; i++) begin
            v = 6'($urandom);
            se = 6'($urandom);
            re = 6'($urandom);
            fab <= fabric_data_t'(4'($urandom));
            ext <= 1'($urandom);
            ctl <= '{1'b0, 1'b0, 1'b0, i[1], i[0]};
            cfg(32'(i[2]), 32'(v), 0, 32'({re, se}), 0, 0);
            rs();
            e = exp7(v, se, re, i[1], i[0]);
            chk("status", e, rdat);
            chk("in_q", 32'(e[1:0]), {in_q1_o, in_q0_o});
            chk("pad_o", 32'(e[2]), pad_o);
            chk("pad_oe_o", !e[4], pad_oe_o);
        end
        // Per-pair enables with sync forcing, then async forcing
        v = 6'($urandom);
        ctl <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        fab <= '{1'b1, 1'b0, 1'b1, 1'b0};
        ext <= 1'b0;
        cfg(0, 32'(v), 0, 32'hFFF, 0, 32'h7);
        ctl <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        rs();
        chk("status hold", 32'h14, rdat);
        ctl.output_pair_clk_en <= 1'b1;
        rs();
        chk("status out pair", 32'(6'h10 | (v & 6'h0C)), rdat);
        ctl.output_pair_clk_en <= 1'b0;
        wb(1'b1, ADDR_CTRL, 32'h1);
        rs();
        chk("status async", exp7(v, 6'h3F, 6'h3F, 1, 0), rdat);
        // Global init loads the separate init values
        w = 6'($urandom);
        ctl <= '0;
        cfg(0, 32'(v), 32'(w), 0, 0, 32'h7);
        wb(1'b1, ADDR_CTRL, 32'h4);
        rs();
        chk("status init", {25'h0, w[4] ? 1'b0 : w[2], w}, rdat);
        // Inverted enables in every pass, with inverted set/reset, then inverted reverse, then neither
        for (int k = 0; k < 3; k++) begin
            v = 6'($urandom);
            fab <= fabric_data_t'(4'($urandom));
            ext <= 1'($urandom);
            cfg(0, 32'(v), 0, 32'hFFF, 32'h7 | ((k < 2) ? 32'h8 << k : 0),
                32'h7);
            rs();
            e = exp7(v, 6'h3F, 6'h3F, k == 0, k == 1);
            chk("status inverted", e, rdat);
        end
        // Forwarded clock: constant one and zero into the DDR pair
        ctl <= '0;
        fab <= '{1'b1, 1'b0, 1'b0, 1'b0};
        cfg(32'h2, 0, 0, 0, 0, 0);
        repeat (8) @(posedge clk_i);
        chk("pad_oe_o", 1, pad_oe_o);
        for (int k = 0; k < 8; k++) begin
            p = pad_o;
            @(posedge clk_i);
            chk("pad_o", !p, pad_o);
        end
        // Mid-run reset returns configuration and elements to defaults
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("pad_o reset", 0, pad_o);
        chk("pad_oe_o reset", 1, pad_oe_o);
        wb(1'b0, ADDR_CTRL, 0);
        chk("ctrl reset", 0, rdat);
        test_done();
    end
endmodule // testbench
